// file: common/rht_pkg.sv
// Constants and types shared by the ride-height range teach sequencer.
// Assumes a single 20 MHz core clock and a millisecond timebase tick.
package rht_pkg;

  // ----------------------------------------------------------------
  // Clock and timebase
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned TICK_PERIOD_NS = 1000000;
  localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Sequence times in milliseconds (one tick each)
  // ----------------------------------------------------------------
  localparam int unsigned TIMER_W = 16;
  localparam logic [15:0] T_HOLD_MS         = 16'd5000;
  localparam logic [15:0] T_WAIT_MS         = 16'd60000;
  localparam logic [15:0] T_ACK_MS          = 16'd3000;
  localparam logic [15:0] T_FAIL_MS         = 16'd5000;
  localparam logic [15:0] T_SELECT_MS       = 16'd8000;
  localparam logic [15:0] T_PULSE_MS        = 16'd30;
  localparam logic [15:0] T_RESTORE_BLINK_MS = 16'd10000;
  localparam logic [15:0] T_CONFIRM_MS      = 16'd200;
  // A pulse of the least length may show one tick short after phase
  localparam logic [15:0] PULSE_ACCEPT_TICKS = T_PULSE_MS - 16'd1;
  // Blink half period is 256 ms
  localparam int unsigned BLINK_BIT = 8;

  // ----------------------------------------------------------------
  // Range in millimetres
  // ----------------------------------------------------------------
  localparam int unsigned POS_W = 10;
  localparam logic [9:0] RANGE_MIN_MM  = 10'd50;
  localparam logic [9:0] RANGE_MAX_MM  = 10'd500;
  localparam logic [9:0] SPAN_MIN_MM   = 10'd10;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    RHT_IDLE        = 4'h0,
    RHT_HOLD        = 4'h1,
    RHT_SELECT      = 4'h2,
    RHT_WAIT1       = 4'h3,
    RHT_HIGH1       = 4'h4,
    RHT_ACK1        = 4'h5,
    RHT_WAIT2       = 4'h6,
    RHT_HIGH2       = 4'h7,
    RHT_OK          = 4'h8,
    RHT_FAIL        = 4'h9,
    RHT_RST_BLINK   = 4'hA,
    RHT_RST_RELEASE = 4'hB,
    RHT_RST_LOW     = 4'hC
  } rht_state_type;

endpackage : rht_pkg

// file: rtl/rht_seq.sv
// Teach sequencer of a laser ride-height sensor: watches the teach pin,
// drives the indicator LED and keeps the measurement range.
// Assumes position_mm is the live distance, on core_clk, in millimetres.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Teach entered after five seconds held high
// - Sixty second wait after first position
// - Sixty second wait for first position
// - LED steady three seconds after first
// - LED steady three seconds on good range
// - LED blinks five seconds on bad range
// - Position pulses of thirty milliseconds accepted
// - Restore needs ten seconds of blinking held
// - Confirm level held 0.2 s before restore
// - Span at least 10 mm inside 50..500
// - Sequences accepted from idle only
module rht_seq
  import rht_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYCLES
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             teach_in,
  input  wire logic [POS_W-1:0] position_mm,
  output var  logic             led,
  output var  logic             teach_active,
  output var  logic [POS_W-1:0] range_lo_mm,
  output var  logic [POS_W-1:0] range_hi_mm,
  output var  logic             range_changed
);

  // ----------------------------------------------------------------
  // Range helpers
  // ----------------------------------------------------------------
  function automatic logic [POS_W-1:0] rht_lower(input logic [POS_W-1:0] a, input logic [POS_W-1:0] b);
    rht_lower = (a < b) ? a : b;
  endfunction : rht_lower

  function automatic logic [POS_W-1:0] rht_upper(input logic [POS_W-1:0] a, input logic [POS_W-1:0] b);
    rht_upper = (a < b) ? b : a;
  endfunction : rht_upper

  function automatic logic rht_span_ok(input logic [POS_W-1:0] a, input logic [POS_W-1:0] b);
    logic [POS_W-1:0] lo;
    logic [POS_W-1:0] hi;
    lo = rht_lower(a, b);
    hi = rht_upper(a, b);
    rht_span_ok = (lo >= RANGE_MIN_MM) && (hi <= RANGE_MAX_MM) && ((hi - lo) >= SPAN_MIN_MM);
  endfunction : rht_span_ok

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic               sync1;
    logic               sync2;
    rht_state_type      st;
    logic [TIMER_W-1:0] timer;
    logic [POS_W-1:0]   pos1;
    logic [POS_W-1:0]   lo;
    logic [POS_W-1:0]   hi;
    logic               led;
    logic               active;
    logic               changed;
  } rht_seq_type;

  localparam rht_seq_type RESET_VALUE = '{
    sync1:   1'b0,
    sync2:   1'b0,
    st:      RHT_IDLE,
    timer:   '0,
    pos1:    '0,
    lo:      RANGE_MIN_MM,
    hi:      RANGE_MAX_MM,
    led:     1'b0,
    active:  1'b0,
    changed: 1'b0
  };

  rht_seq_type r;
  rht_seq_type next_r;
  logic        tick;
  logic        pin;

  // ----------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------
  rht_tick #(
    .CYCLES (TICK_CYC)
  ) u_tick (
    .core_clk (core_clk),
    .rst      (rst),
    .tick     (tick)
  );

  // Outputs straight from the state register
  assign pin           = r.sync2;
  assign led           = r.led;
  assign teach_active  = r.active;
  assign range_lo_mm   = r.lo;
  assign range_hi_mm   = r.hi;
  assign range_changed = r.changed;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Timer counts ticks in the current state and restarts on each move except into RHT_IDLE, RHT_RST_BLINK and RHT_RST_RELEASE
  always_comb begin
    next_r = r;
    next_r.sync1 = teach_in;
    next_r.sync2 = r.sync1;
    next_r.changed = 1'b0;
    if (tick && (r.timer != {TIMER_W{1'b1}})) begin
      next_r.timer = r.timer + 16'h0001;
    end
    unique case (r.st)
      RHT_IDLE: begin
        next_r.led = 1'b0;
        next_r.active = 1'b0;
        if (pin) begin
          next_r.st = RHT_HOLD;
          next_r.timer = '0;
        end
      end
      RHT_HOLD: begin
        if (!pin) begin
          next_r.st = RHT_IDLE;
        end else if (r.timer >= T_HOLD_MS) begin
          next_r.st = RHT_SELECT;
          next_r.timer = '0;
          next_r.active = 1'b1;
        end
      end
      RHT_SELECT: begin
        next_r.led = r.timer[BLINK_BIT];
        if (!pin) begin
          next_r.st = RHT_WAIT1;
          next_r.timer = '0;
          next_r.led = 1'b0;
        end else if (r.timer >= T_SELECT_MS) begin
          next_r.st = RHT_RST_BLINK;
        end
      end
      RHT_WAIT1, RHT_WAIT2: begin
        next_r.led = 1'b0;
        if (pin) begin
          next_r.st = (r.st == RHT_WAIT1) ? RHT_HIGH1 : RHT_HIGH2;
          next_r.timer = '0;
        end else if (r.timer >= T_WAIT_MS) begin
          next_r.st = RHT_IDLE;
        end
      end
      RHT_HIGH1: begin
        if (!pin) begin
          next_r.timer = '0;
          if (r.timer >= PULSE_ACCEPT_TICKS) begin
            next_r.st = RHT_ACK1;
            next_r.pos1 = position_mm;
            next_r.led = 1'b1;
          end else begin
            next_r.st = RHT_WAIT1;
          end
        end
      end
      RHT_ACK1: begin
        if (r.timer >= T_ACK_MS) begin
          next_r.st = RHT_WAIT2;
          next_r.timer = '0;
          next_r.led = 1'b0;
        end
      end
      RHT_HIGH2: begin
        if (!pin) begin
          next_r.timer = '0;
          if (r.timer < PULSE_ACCEPT_TICKS) begin
            next_r.st = RHT_WAIT2;
          end else if (rht_span_ok(r.pos1, position_mm)) begin
            next_r.st = RHT_OK;
            next_r.led = 1'b1;
            next_r.lo = rht_lower(r.pos1, position_mm);
            next_r.hi = rht_upper(r.pos1, position_mm);
            next_r.changed = 1'b1;
          end else begin
            next_r.st = RHT_FAIL;
          end
        end
      end
      RHT_OK: begin
        if (r.timer >= T_ACK_MS) begin
          next_r.st = RHT_IDLE;
        end
      end
      RHT_FAIL: begin
        next_r.led = ~r.timer[BLINK_BIT];
        if (r.timer >= T_FAIL_MS) begin
          next_r.st = RHT_IDLE;
        end
      end
      RHT_RST_BLINK: begin
        next_r.led = r.timer[BLINK_BIT];
        if (!pin) begin
          next_r.st = RHT_IDLE;
        end else if (r.timer >= T_RESTORE_BLINK_MS) begin
          next_r.st = RHT_RST_RELEASE;
          next_r.led = 1'b0;
        end
      end
      RHT_RST_RELEASE: begin
        if (!pin) begin
          next_r.st = RHT_RST_LOW;
          next_r.timer = '0;
        end
      end
      RHT_RST_LOW: begin
        if (pin) begin
          next_r.st = RHT_IDLE;
        end else if (r.timer >= T_CONFIRM_MS) begin
          next_r.st = RHT_IDLE;
          next_r.lo = RANGE_MIN_MM;
          next_r.hi = RANGE_MAX_MM;
          next_r.changed = 1'b1;
        end
      end
      default: begin
        next_r.st = RHT_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      r <= RESET_VALUE;
    end else begin
      r <= next_r;
    end
  end

endmodule : rht_seq
`default_nettype wire

// file: rtl/rht_tick.sv
// Timebase divider: one-cycle enable pulse every CYCLES clocks.
// Assumes core_clk is the only clock and rst is asynchronous, active high.
`timescale 1ns/1ps
`default_nettype none
module rht_tick
  import rht_pkg::*;
#(
  parameter int unsigned CYCLES = TICK_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic rst,
  output var  logic tick
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (CYCLES < 2 || CYCLES > 65536) begin : g_bad_cycles
    $error("rht_tick: CYCLES must lie in 2..65536");
  end

  typedef struct packed {
    logic [15:0] count;
    logic        tick;
  } rht_tick_type;

  rht_tick_type r;
  rht_tick_type next_r;

  localparam logic [15:0] LAST = 16'(CYCLES - 1);

  assign tick = r.tick;

  // Count up the period and pulse at its end
  always_comb begin
    next_r = r;
    next_r.tick = 1'b0;
    if (r.count == LAST) begin
      next_r.count = 16'h0000;
      next_r.tick = 1'b1;
    end else begin
      next_r.count = r.count + 16'h0001;
    end
  end

  // State register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

endmodule : rht_tick
`default_nettype wire

// file: tb/rht_seq_sva.sv
// Port checker for the teach sequencer.
// Assumes it is bound onto rht_seq with the same TICK_CYC.
`timescale 1ns/1ps
`default_nettype none
module rht_seq_chk
  import rht_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYCLES
) (
  input wire logic             core_clk,
  input wire logic             rst,
  input wire logic             teach_in,
  input wire logic [POS_W-1:0] position_mm,
  input wire logic             led,
  input wire logic             teach_active,
  input wire logic [POS_W-1:0] range_lo_mm,
  input wire logic [POS_W-1:0] range_hi_mm,
  input wire logic             range_changed
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [31:0] hi_cnt;
  logic [31:0] last_hi;
  logic [31:0] led_cnt;
  // Run lengths of the raw pin and of a lit LED
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hi_cnt <= '0;
      last_hi <= '0;
      led_cnt <= '0;
    end else begin
      hi_cnt <= teach_in ? hi_cnt + 1 : '0;
      if (!teach_in && hi_cnt != 0) last_hi <= hi_cnt;
      led_cnt <= led ? led_cnt + 1 : '0;
    end
  end
  property p_hold; $rose(teach_active) |-> hi_cnt >= 32'(T_HOLD_MS - 16'h1) * TICK_CYC; endproperty
  a_hold: assert property (p_hold) else $error("teach entered early");
  property p_sel_off; $rose(teach_active) |-> !led [*8]; endproperty
  a_sel_off: assert property (p_sel_off) else $error("blink not starting dark");
  property p_dark; !teach_active |-> !led; endproperty
  a_dark: assert property (p_dark) else $error("led lit while idle");
  property p_steady; led_cnt <= 32'(T_ACK_MS + 16'h1) * TICK_CYC; endproperty
  a_steady: assert property (p_steady) else $error("led lit too long");
  property p_pulse; range_changed |-> last_hi >= 28 * TICK_CYC; endproperty
  a_pulse: assert property (p_pulse) else $error("range set without long pulse");
  property p_span;
    range_changed |-> range_lo_mm >= RANGE_MIN_MM && range_hi_mm <= RANGE_MAX_MM
      && range_hi_mm - range_lo_mm >= SPAN_MIN_MM;
  endproperty
  a_span: assert property (p_span) else $error("bad range stored");
  property p_one; range_changed |=> !range_changed; endproperty
  a_one: assert property (p_one) else $error("change flag too long");
  property p_still; $changed(range_lo_mm) || $changed(range_hi_mm) |-> range_changed; endproperty
  a_still: assert property (p_still) else $error("range moved silently");
  c_change: cover property (range_changed);
  c_teach: cover property ($rose(teach_active));
  c_blink: cover property ($fell(led) && teach_active);
endmodule : rht_seq_chk
bind rht_seq rht_seq_chk #(.TICK_CYC(TICK_CYC)) i_rht_seq_chk (.core_clk(core_clk), .rst(rst),
  .teach_in(teach_in), .position_mm(position_mm), .led(led), .teach_active(teach_active),
  .range_lo_mm(range_lo_mm), .range_hi_mm(range_hi_mm), .range_changed(range_changed));
`default_nettype wire

// file: tb/rht_teach_drv.sv
// Model of the controller or switch on the teach pin.
// Assumes the bench calls drive() in sequence, on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module rht_teach_drv
  import rht_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYCLES
) (
  input wire logic core_clk,
  output var logic teach_in
);
  initial teach_in = 1'b0;
  // Holds one level for a whole number of milliseconds
  task automatic drive(input logic lvl, input int ms);
    @(negedge core_clk);
    teach_in = lvl;
    repeat (ms * TICK_CYC - 1) @(negedge core_clk);
  endtask : drive
endmodule : rht_teach_drv
`default_nettype wire

// file: tb/ride_height_range_teach_sequencer_tb_top.sv
// Self-checking bench: teach a random range, refuse a zero span, then restore the default.
// Assumes a 2-cycle tick to keep the run short.
`timescale 1ns/1ps
`default_nettype none
module ride_height_range_teach_sequencer_tb_top
  import rht_pkg::*;
();
  localparam int unsigned TC = 2;
  logic             core_clk;
  logic             rst;
  logic             teach_in;
  logic [POS_W-1:0] position_mm;
  logic             led;
  logic             teach_active;
  logic [POS_W-1:0] range_lo_mm;
  logic [POS_W-1:0] range_hi_mm;
  logic             range_changed;
  logic [POS_W-1:0] pa, pb, lo_e, hi_e;
  int               failures, comparisons, cycles;
  rht_seq #(.TICK_CYC(TC)) i_rht_seq (.core_clk(core_clk), .rst(rst), .teach_in(teach_in),
    .position_mm(position_mm), .led(led), .teach_active(teach_active), .range_lo_mm(range_lo_mm),
    .range_hi_mm(range_hi_mm), .range_changed(range_changed));
  rht_teach_drv #(.TICK_CYC(TC)) i_rht_teach_drv (.core_clk(core_clk), .teach_in(teach_in));
  // ----------------------------------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // Cuts a hang short
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 90000) begin
      failures++;
      $display("MISMATCH timeout expected end seen hang");
      end_sim();
    end
  end
  function automatic logic [POS_W-1:0] min_of(input logic [POS_W-1:0] a, input logic [POS_W-1:0] b);
    return (a < b) ? a : b;
  endfunction : min_of
  task automatic check(input string what, input logic [POS_W-1:0] exp, input logic [POS_W-1:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
    end
  endtask : check
  task automatic wait_chg();
    int n;
    n = 0;
    while (range_changed !== 1'b1 && n < 300) begin
      @(negedge core_clk);
      n++;
    end
    check("range_changed", 10'h1, 10'(range_changed));
  endtask : wait_chg
  task automatic end_sim();
    $display("checks %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    failures = 0;
    comparisons = 0;
    cycles = 0;
    rst = 1'b1;
    position_mm = RANGE_MIN_MM;
    void'($urandom(32'hC92D3B6A));
    lo_e = RANGE_MIN_MM + 10'($urandom % 441);
    hi_e = lo_e + SPAN_MIN_MM + 10'($urandom % (RANGE_MAX_MM - lo_e - SPAN_MIN_MM + 1));
    if ($urandom % 2) hi_e = lo_e + SPAN_MIN_MM; // Corner: narrowest span
    pa = ($urandom % 2) ? hi_e : lo_e;
    pb = (pa == lo_e) ? hi_e : lo_e;
    repeat (16) @(negedge core_clk);
    rst = 1'b0;
    i_rht_teach_drv.drive(1'b1, 100);
    i_rht_teach_drv.drive(1'b0, 10);
    check("teach_active", 10'h0, 10'(teach_active));
    $display("test short_hold done");
    i_rht_teach_drv.drive(1'b1, 5003);
    check("teach_active", 10'h1, 10'(teach_active));
    i_rht_teach_drv.drive(1'b0, 20);
    i_rht_teach_drv.drive(1'b1, 10);
    i_rht_teach_drv.drive(1'b0, 10);
    check("led", 10'h0, 10'(led));
    position_mm = pa;
    i_rht_teach_drv.drive(1'b1, 30);
    i_rht_teach_drv.drive(1'b0, 10);
    check("led", 10'h1, 10'(led));
    check("range_lo_mm", RANGE_MIN_MM, range_lo_mm);
    i_rht_teach_drv.drive(1'b0, 3010);
    check("led", 10'h0, 10'(led));
    position_mm = pb;
    i_rht_teach_drv.drive(1'b1, 30);
    fork
      i_rht_teach_drv.drive(1'b0, 3010);
      begin
        wait_chg();
        check("range_lo_mm", min_of(pa, pb), range_lo_mm);
        check("range_hi_mm", hi_e, range_hi_mm);
        repeat (3) @(negedge core_clk);
        check("led", 10'h1, 10'(led));
      end
    join
    check("teach_active", 10'h0, 10'(teach_active));
    $display("test teach done");
    // Corner: both positions equal, so the span is refused
    i_rht_teach_drv.drive(1'b1, 5003);
    i_rht_teach_drv.drive(1'b0, 20);
    position_mm = pa;
    i_rht_teach_drv.drive(1'b1, 30);
    i_rht_teach_drv.drive(1'b0, 3010);
    i_rht_teach_drv.drive(1'b1, 30);
    i_rht_teach_drv.drive(1'b0, 100);
    check("led", 10'h1, 10'(led));
    i_rht_teach_drv.drive(1'b0, 200);
    check("led", 10'h0, 10'(led));
    check("range_lo_mm", lo_e, range_lo_mm);
    check("range_hi_mm", hi_e, range_hi_mm);
    i_rht_teach_drv.drive(1'b0, 4800);
    check("teach_active", 10'h0, 10'(teach_active));
    $display("test fail done");
    i_rht_teach_drv.drive(1'b1, 15010);
    check("led", 10'h0, 10'(led));
    i_rht_teach_drv.drive(1'b0, 190);
    check("range_hi_mm", hi_e, range_hi_mm);
    fork
      i_rht_teach_drv.drive(1'b0, 40);
      wait_chg();
    join
    check("range_lo_mm", RANGE_MIN_MM, range_lo_mm);
    check("range_hi_mm", RANGE_MAX_MM, range_hi_mm);
    $display("test restore done");
    end_sim();
  end
endmodule : ride_height_range_teach_sequencer_tb_top
`default_nettype wire
